// File: logic/sam_addr_mux.sv
// Purpose: Drives the shared 22-pin external address bus for all banks.
// Assumes: One clock; requests and settings are synchronous to it.
// Notes:   SDRAM start, row-to-column gap and end wait on ticks from the SDRAM clock input.
//
// Functional notes
// - One 22-bit bus shared by all banks.
// - Top pins: address 21/20 or bank select.
// - SDRAM row and column from internal address.
// - Column width programmable from 8 to 11.
// - SDRAM address on low 13, bank top.
// - Other cycles drive the full byte address.
// - Memory banks get width-dependent address shift.
// - I/O banks get no width adjustment.
// - System clock is driven out as SDRAM clock.
// - SDRAM logic timed from SDRAM clock input.
`timescale 1ns/1ps
module sam_addr_mux
  import sam_pkg::*;
#(
  parameter int ASYNC_HOLD = ASYNC_HOLD_CYC,
  parameter int RCD_WAIT   = RCD_TICKS
)
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       sdram_clock_feedback_in,
  input  wire logic [1:0] col_width_sel,
  input  wire logic       req_valid,
  input  wire sam_req_s   req,
  output logic            req_ready,
  output logic [19:0]     addr_low,
  output logic            bank_select_high,
  output logic            bank_select_low,
  output logic            ras_n,
  output logic            cas_n,
  output logic            sdram_cycle,
  output logic            done,
  output logic            system_clock_out
);

  // Sequencer states. The SDRAM path takes several states because its start,
  // row-to-column gap and end must wait for the SDRAM clock; the plain path only counts the
  // hold time.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ASYNC,
    ST_SD_START,
    ST_SD_ROW,
    ST_SD_WAIT,
    ST_SD_COL,
    ST_SD_END
  } sam_state_e;

  sam_state_e   state_ff;
  sam_state_e   nxt_state;
  sam_req_s     req_ff;
  logic [1:0]   colw_ff;
  logic [7:0]   count_ff;
  logic [7:0]   nxt_count;
  logic         fb_tick;
  sam_sd_addr_s sd_addr;
  logic [21:0]  async_addr;
  logic [21:0]  pins_ff;
  logic [21:0]  nxt_pins;
  logic         ras_n_ff;
  logic         cas_n_ff;
  logic         done_ff;
  logic         nxt_ras_n;
  logic         nxt_cas_n;
  logic         nxt_done;
  logic         accept;

  // Last count of each wait; the counters start at zero, so one is taken
  // off. Both parameters must be at least one.
  localparam logic [7:0] ASYNC_LAST = 8'(ASYNC_HOLD - 1);
  localparam logic [7:0] RCD_LAST   = 8'(RCD_WAIT - 1);

  // The internal clock leaves the chip unchanged; it is a forwarded clock,
  // so no flop is placed in its path.
  assign system_clock_out = clock;

  // SDRAM pacing comes from the SDRAM clock input, sampled into this domain.
  // The input must run at no more than half the system rate.
  sam_edge_sync u_fb_sync
  (
    .clock      (clock),
    .nrst       (nrst),
    .raw_in     (sdram_clock_feedback_in),
    .rise_pulse (fb_tick)
  );

  // Bank, row and column of the captured request.
  sam_sdram_split u_split
  (
    .byte_addr     (req_ff.addr),
    .width         (req_ff.width),
    .col_width_sel (colw_ff),
    .sd_addr       (sd_addr)
  );

  // A request is taken only while the sequencer is idle.
  assign req_ready = (state_ff == ST_IDLE);
  assign accept    = req_valid && req_ready;

  // Capture the request and the column width for the whole access, so a
  // change of setting in mid-access cannot tear the address.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      req_ff  <= '0;
      colw_ff <= 2'h0;
    end
    else if (accept)
    begin
      req_ff  <= req;
      colw_ff <= col_width_sel;
    end
  end

  // Plain byte address: memory banks are shifted down by their width so
  // they wire one-to-one; I/O banks see the raw byte address.
  always_comb
  begin
    if (req_ff.kind == SAM_IO)
    begin
      async_addr = req_ff.addr[ADDR_PINS-1:0];
    end
    else
    begin
      async_addr = 22'(req_ff.addr >> sam_width_shift(req_ff.width));
    end
  end

  // Next state, counter, pins and strobes.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_pins  = pins_ff;
    nxt_ras_n = STRB_RST;
    nxt_cas_n = STRB_RST;
    nxt_done  = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        // The count is cleared here so a value left by an earlier access
        // can never shorten the next one.
        nxt_count = 8'h00;
        if (req_valid)
        begin
          if (req.kind == SAM_SDRAM)
          begin
            nxt_state = ST_SD_START;
          end
          else
          begin
            nxt_state = ST_ASYNC;
          end
        end
      end
      ST_ASYNC:
      begin
        // The whole bus carries the byte address, top pins included.
        nxt_pins = async_addr;
        if (count_ff == ASYNC_LAST)
        begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
          nxt_count = 8'h00;
        end
        else
        begin
          nxt_count = count_ff + 8'h01;
        end
      end
      ST_SD_START:
      begin
        // Wait for the SDRAM clock before the row phase.
        if (fb_tick)
        begin
          nxt_state = ST_SD_ROW;
        end
      end
      ST_SD_ROW:
      begin
        // Row on the low 13 pins, bank select on the top two.
        nxt_pins  = {sd_addr.bank, 7'h00, sd_addr.row};
        nxt_ras_n = 1'b0;
        nxt_state = ST_SD_WAIT;
        nxt_count = 8'h00;
      end
      ST_SD_WAIT:
      begin
        // Bank bits stay put while the row settles. The gap is counted in
        // SDRAM clock ticks, not system cycles, so it scales with that
        // clock's rate.
        nxt_pins = {sd_addr.bank, pins_ff[LOW_PINS-1:0]};
        if (fb_tick)
        begin
          if (count_ff == RCD_LAST)
          begin
            nxt_state = ST_SD_COL;
          end
          else
          begin
            nxt_count = count_ff + 8'h01;
          end
        end
      end
      ST_SD_COL:
      begin
        // Column with the programmed width, same bank.
        nxt_pins  = {sd_addr.bank, 7'h00, sd_addr.col};
        nxt_cas_n = 1'b0;
        nxt_state = ST_SD_END;
      end
      ST_SD_END:
      begin
        // The column stays on the pins until the SDRAM clock has had an
        // edge to sample it; only then is the access reported done.
        if (fb_tick)
        begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end
      end
      default:
      begin
        // An unused state code falls back to idle rather than hanging.
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and step counter.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      count_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  // Pin drivers are registered so the bus never glitches between phases.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pins_ff <= {BANK_RST, LOW_RST};
    end
    else
    begin
      pins_ff <= nxt_pins;
    end
  end

  // Strobes are one-cycle low pulses; they idle high.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ras_n_ff <= STRB_RST;
      cas_n_ff <= STRB_RST;
    end
    else
    begin
      ras_n_ff <= nxt_ras_n;
      cas_n_ff <= nxt_cas_n;
    end
  end

  // Completion pulse.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= nxt_done;
    end
  end

  // Pin outputs; the top two pins double as bank select.
  assign addr_low         = pins_ff[LOW_PINS-1:0];
  assign bank_select_high = pins_ff[ADDR_PINS-1];
  assign bank_select_low  = pins_ff[LOW_PINS];
  assign ras_n            = ras_n_ff;
  assign cas_n            = cas_n_ff;
  assign done             = done_ff;

  // High through the whole SDRAM access, start to completion.
  // It is decoded from the state register alone, so inputs cannot glitch it.
  assign sdram_cycle = (state_ff == ST_SD_START) || (state_ff == ST_SD_ROW) ||
                       (state_ff == ST_SD_WAIT) || (state_ff == ST_SD_COL) ||
                       (state_ff == ST_SD_END);

endmodule

// File: logic/sam_edge_sync.sv
// Purpose: Brings the SDRAM clock input into the clock domain as a tick.
// Assumes: The input toggles slower than half the system clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module sam_edge_sync
  import sam_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic raw_in,
  output logic      rise_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Two-stage synchroniser followed by an edge history flop.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // One-cycle pulse on each rising edge of the synchronised input.
  assign rise_pulse = sync_ff & ~last_ff;

endmodule

// File: logic/sam_pkg.sv
// Purpose: Shared constants and types for the shared memory address mux.
// Assumes: One 10 MHz clock; the internal byte address is 26 bits (64 MB).
// Notes:   Every figure the block uses is named here once.
package sam_pkg;

  // Pin counts and field positions of the external address bus.
  localparam int ADDR_PINS    = 22;
  localparam int LOW_PINS     = 20;
  localparam int SD_PINS      = 13;
  localparam int BANK_BITS    = 2;
  localparam int INT_ADDR_W   = 26;
  localparam int COL_MIN      = 8;
  localparam int COL_MAX      = 11;

  // Reset values of the pin drivers.
  localparam logic [19:0] LOW_RST  = 20'h00000;
  localparam logic [1:0]  BANK_RST = 2'h0;
  localparam logic        STRB_RST = 1'b1;

  // Timing: the figures are in ns, the counts derive from the clock period.
  localparam int CLK_PERIOD_NS = 100;
  localparam int ASYNC_HOLD_NS = 200;
  localparam int RCD_NS        = 20;
  localparam int ASYNC_HOLD_CYC =
    ((ASYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (ASYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_TICKS =
    ((RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Kind of bank addressed by a transfer.
  typedef enum logic [2:0] {
    SAM_ROM,
    SAM_SRAM,
    SAM_FLASH,
    SAM_SDRAM,
    SAM_IO
  } sam_kind_e;

  // Data width of the addressed bank.
  typedef enum logic [1:0] {
    SAM_W8,
    SAM_W16,
    SAM_W32
  } sam_width_e;

  // One transfer request.
  typedef struct packed {
    sam_kind_e               kind;
    sam_width_e              width;
    logic [INT_ADDR_W-1:0]   addr;
  } sam_req_s;

  // Split SDRAM address.
  typedef struct packed {
    logic [BANK_BITS-1:0] bank;
    logic [SD_PINS-1:0]   row;
    logic [SD_PINS-1:0]   col;
  } sam_sd_addr_s;

  // Byte-to-word shift for a bank width.
  function automatic logic [1:0] sam_width_shift(input sam_width_e w);
    case (w)
      SAM_W16: sam_width_shift = 2'h1;
      SAM_W32: sam_width_shift = 2'h2;
      default: sam_width_shift = 2'h0;
    endcase
  endfunction

endpackage

// File: logic/sam_sdram_split.sv
// Purpose: Splits an internal byte address into SDRAM bank, row and column.
// Assumes: Column width code 0..3 means 8..11 column bits.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module sam_sdram_split
  import sam_pkg::*;
(
  input  wire logic [INT_ADDR_W-1:0] byte_addr,
  input  wire sam_width_e            width,
  input  wire logic [1:0]            col_width_sel,
  output sam_sd_addr_s               sd_addr
);

  logic [INT_ADDR_W-1:0] word_addr;
  logic [3:0]            col_bits;
  logic [INT_ADDR_W-1:0] col_mask;
  logic [INT_ADDR_W-1:0] row_full;
  logic [INT_ADDR_W-1:0] bank_full;

  // The bank width turns the byte address into a word address first.
  always_comb
  begin
    word_addr = byte_addr >> sam_width_shift(width);
    col_bits  = 4'(COL_MIN) + {2'h0, col_width_sel};
    col_mask  = (INT_ADDR_W'(1) << col_bits) - INT_ADDR_W'(1);
    row_full  = word_addr >> col_bits;
    bank_full = row_full >> SD_PINS;
    sd_addr.col  = SD_PINS'(word_addr & col_mask);
    sd_addr.row  = row_full[SD_PINS-1:0];
    sd_addr.bank = bank_full[BANK_BITS-1:0];
  end

endmodule

// File: tb/sam_addr_mux_monitor.sv
// Purpose: Pin checker for the address mux.
// Assumes: One clock; nrst is active low.
// Notes:   Bound to the design below.
`timescale 1ns/1ps
module sam_addr_mux_monitor
  import sam_pkg::*;
#(
  parameter int ASYNC_HOLD = ASYNC_HOLD_CYC
)
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        req_valid,
  input wire sam_req_s    req,
  input wire logic        req_ready,
  input wire logic [19:0] addr_low,
  input wire logic        bank_select_high,
  input wire logic        bank_select_low,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        sdram_cycle,
  input wire logic        done
);
  localparam int LAT = ASYNC_HOLD + 1;
  logic rowed_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Set by the row strobe; the bank may not move until the access ends.
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      rowed_ff <= 1'b0;
    else if (!ras_n)
      rowed_ff <= 1'b1;
    else if (!sdram_cycle)
      rowed_ff <= 1'b0;
  // A request taken this cycle.
  sequence take_s;
    req_valid && req_ready;
  endsequence
  // Either strobe active.
  sequence strobe_s;
    !ras_n || !cas_n;
  endsequence
  ras_pulse_a: assert property (!ras_n |=> ras_n) else $error("long row strobe");
  cas_pulse_a: assert property (!cas_n |=> cas_n) else $error("long col strobe");
  col_after_a: assert property (!cas_n |-> rowed_ff) else $error("col before row");
  bank_hold_a: assert property (rowed_ff && sdram_cycle |->
    $stable({bank_select_high, bank_select_low})) else $error("bank moved");
  strobe_sd_a: assert property (strobe_s |-> sdram_cycle) else $error("stray strobe");
  sd_upper_a: assert property (strobe_s |-> addr_low[19:13] == 7'h00)
    else $error("upper pins set");
  async_lat_a: assert property (take_s ##0 req.kind != SAM_SDRAM |-> ##LAT done)
    else $error("async done late");
  sd_enter_a: assert property (take_s ##0 req.kind == SAM_SDRAM |=> sdram_cycle)
    else $error("no sdram cycle");
  busy_a: assert property (take_s |=> !req_ready) else $error("ready while busy");
endmodule

bind sam_addr_mux sam_addr_mux_monitor #(.ASYNC_HOLD(ASYNC_HOLD)) sam_addr_mux_monitor_inst
(
  .clock            (clock),
  .nrst             (nrst),
  .req_valid        (req_valid),
  .req              (req),
  .req_ready        (req_ready),
  .addr_low         (addr_low),
  .bank_select_high (bank_select_high),
  .bank_select_low  (bank_select_low),
  .ras_n            (ras_n),
  .cas_n            (cas_n),
  .sdram_cycle      (sdram_cycle),
  .done             (done)
);

// File: tb/sam_addr_mux_tb.sv
// Purpose: Bench for the address mux.
// Assumes: Default timing parameters.
// Notes:   The model makes the feedback clock.
`timescale 1ns/1ps
module sam_addr_mux_tb
  import sam_pkg::*;
;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        slow = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  col_width_sel = 2'h0;
  sam_req_s    req = '0;
  logic        req_ready, bank_select_high, bank_select_low, ras_n, cas_n;
  logic        sdram_cycle, done, system_clock_out, sdram_clock_feedback_in;
  logic [19:0] addr_low;
  logic [14:0] row_seen, col_seen;
  logic [21:0] pins;
  int          fails = 0;
  int          checked = 0;
  int          lat, fast, sd_hi;

  assign pins = {bank_select_high, bank_select_low, addr_low};
  always #50 clock = !clock;
  sam_addr_mux sam_addr_mux_inst
  (
    .clock                   (clock),
    .nrst                    (nrst),
    .sdram_clock_feedback_in (sdram_clock_feedback_in),
    .col_width_sel           (col_width_sel),
    .req_valid               (req_valid),
    .req                     (req),
    .req_ready               (req_ready),
    .addr_low                (addr_low),
    .bank_select_high        (bank_select_high),
    .bank_select_low         (bank_select_low),
    .ras_n                   (ras_n),
    .cas_n                   (cas_n),
    .sdram_cycle             (sdram_cycle),
    .done                    (done),
    .system_clock_out        (system_clock_out)
  );
  sam_sdram_model sam_sdram_model_inst
  (
    .system_clock_out        (system_clock_out),
    .nrst                    (nrst),
    .slow                    (slow),
    .ras_n                   (ras_n),
    .cas_n                   (cas_n),
    .bank_select_high        (bank_select_high),
    .bank_select_low         (bank_select_low),
    .addr_low                (addr_low),
    .sdram_clock_feedback_in (sdram_clock_feedback_in),
    .row_seen                (row_seen),
    .col_seen                (col_seen)
  );

  // Compares and counts.
  task automatic check(input string nm, input logic [25:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints counts and verdict, then stops.
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Word address after the width shift of a memory bank.
  function automatic logic [25:0] word_of(input logic [25:0] a, input sam_width_e w);
    return (w == SAM_W32) ? a >> 2 : (w == SAM_W16) ? a >> 1 : a;
  endfunction

  // One access; lat counts cycles from take to done, bounded so a hang ends.
  task automatic access(input sam_kind_e k, input sam_width_e w, input logic [25:0] a,
                        input logic [1:0] c);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{k, w, a};
    col_width_sel <= c;
    @(posedge clock);
    req_valid <= 1'b0;
    lat = 0;
    sd_hi = 0;
    while (done !== 1'b1 && lat < 400)
    begin
      @(negedge clock);
      lat++;
      if (sdram_cycle === 1'b1)
        sd_hi++;
    end
    if (lat >= 400)
    begin
      fails++;
      end_of_test();
    end
  endtask

  // Reset levels and the forwarded clock.
  task automatic t_reset();
    #10;
    check("pins", pins, 26'h0);
    check("strobes", {ras_n, cas_n, done, req_ready}, 26'hD);
    check("sd_idle", sdram_cycle, 26'h0);
    check("clk_hi", system_clock_out, clock);
    #50;
    check("clk_lo", system_clock_out, clock);
  endtask

  // Every plain bank kind and width, back to back.
  task automatic t_async();
    logic [25:0] e;
    for (int i = 0; i < 5; i++)
      for (int j = 0; j < 3; j++)
        if (sam_kind_e'(i) != SAM_SDRAM)
        begin
          e = (sam_kind_e'(i) == SAM_IO) ? 26'h2F5A6B7 : word_of(26'h2F5A6B7, sam_width_e'(j));
          access(sam_kind_e'(i), sam_width_e'(j), 26'h2F5A6B7, 2'h0);
          check("lat", 26'(lat), 26'(ASYNC_HOLD_CYC + 1));
          check("pins", pins, e[21:0]);
          check("sd_cyc", 26'(sd_hi), 26'h0);
        end
  endtask

  // Every column width; row and column as the memory latched them.
  task automatic t_sdram(input sam_width_e w, input logic s);
    logic [25:0] e;
    int c;
    slow <= s;
    e = word_of(26'h3C9A5E3, w);
    for (int i = 0; i < 4; i++)
    begin
      c = 8 + i;
      access(SAM_SDRAM, w, 26'h3C9A5E3, 2'(i));
      check("row", row_seen, {2'(e >> (c + 13)), 13'(e >> c)});
      check("col", col_seen, {2'(e >> (c + 13)), 13'(e & ((26'h1 << c) - 1))});
      check("sd_cyc", 26'(sd_hi > 0), 26'h1);
      check("sd_end", sdram_cycle, 26'h0);
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    t_reset();
    @(posedge clock);
    nrst <= 1'b1;
    t_async();
    t_sdram(SAM_W32, 1'b0);
    fast = lat;
    t_sdram(SAM_W8, 1'b1);
    check("slow", 26'(lat > fast), 26'h1);
    end_of_test();
  end
endmodule

// File: tb/sam_sdram_model.sv
// Purpose: Memory side: feedback clock and strobe capture.
// Assumes: Runs on the forwarded clock.
// Notes:   slow stretches the feedback period.
`timescale 1ns/1ps
module sam_sdram_model
  import sam_pkg::*;
(
  input  wire logic        system_clock_out,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        bank_select_high,
  input  wire logic        bank_select_low,
  input  wire logic [19:0] addr_low,
  output logic             sdram_clock_feedback_in,
  output logic [14:0]      row_seen,
  output logic [14:0]      col_seen
);
  logic [3:0] div_ff;
  // Loops the forwarded clock back divided, so it stays below half rate.
  always_ff @(posedge system_clock_out or negedge nrst)
    if (!nrst)
    begin
      div_ff <= 4'h0;
      sdram_clock_feedback_in <= 1'b0;
    end
    else if (div_ff >= (slow ? 4'h5 : 4'h1))
    begin
      div_ff <= 4'h0;
      sdram_clock_feedback_in <= !sdram_clock_feedback_in;
    end
    else
      div_ff <= div_ff + 4'h1;
  // Latches bank and address lines on each strobe, as a memory does.
  always_ff @(posedge system_clock_out)
  begin
    if (!ras_n)
      row_seen <= {bank_select_high, bank_select_low, addr_low[12:0]};
    if (!cas_n)
      col_seen <= {bank_select_high, bank_select_low, addr_low[12:0]};
  end
endmodule
